// file: rtl/prs_pkg.sv
/*
  Constants for the rail sequencer: I2C address, register map,
  setpoint codes and startup timing.
  Assumes a 20 MHz system clock.
*/
package prs_pkg;
  localparam int          CLK_MHZ          = 20;
  localparam int          STARTUP_DELAY_NS = 41000;
  localparam int          STARTUP_CYCLES   =
    (STARTUP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0]  SLAVE_ADDR       = 7'h53;
  localparam logic [7:0]  REG_DEVICE_IDENTITY = 8'h7D;
  localparam logic [7:0]  REG_PRIMARY_SETPOINT_4   = 8'h10;
  localparam logic [7:0]  REG_ALTERNATE_SETPOINT_4 = 8'h11;
  localparam logic [7:0]  REG_RAIL_STATUS  = 8'h12;
  // Setpoint codes in 10 mV units; 120 = 1.2 V, 110 = 1.1 V
  localparam logic [7:0]  PRIMARY_RESET    = 8'h78;
  localparam logic [7:0]  ALTERNATE_RESET  = 8'h6E;
  localparam logic [7:0]  UNMAPPED_READ    = 8'h00;
  localparam int          DELAY_W          = 11;
  typedef enum logic [3:0]
  {
    RAIL_OFF   = 4'h1,
    RAIL_DELAY = 4'h2,
    RAIL_RAMP  = 4'h4,
    RAIL_ON    = 4'h8
  } prs_rail_t;
  localparam int          RAMP_CYCLES      = 16;
endpackage

// file: rtl/prs_rail_ctl.sv
/*
  One rail enable with startup delay then soft-start ramp.
  Assumes trigger is synchronous to mclk_i.
*/
`timescale 1ns/1ps
module prs_rail_ctl
(
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic trigger_i,
  output logic      enable_o,
  output logic      good_o
);
  prs_pkg::prs_rail_t            state_r;
  logic [prs_pkg::DELAY_W-1:0]   cnt_r;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i || !trigger_i)
    begin
      state_r <= prs_pkg::RAIL_OFF;
      cnt_r   <= '0;
    end
    else
    begin
      case (state_r)
        prs_pkg::RAIL_OFF:
        begin
          state_r <= prs_pkg::RAIL_DELAY;
          cnt_r   <= '0;
        end
        prs_pkg::RAIL_DELAY:
        begin
          if (cnt_r == prs_pkg::DELAY_W'(prs_pkg::STARTUP_CYCLES - 1))
          begin
            state_r <= prs_pkg::RAIL_RAMP;
            cnt_r   <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        prs_pkg::RAIL_RAMP:
        begin
          if (cnt_r == prs_pkg::DELAY_W'(prs_pkg::RAMP_CYCLES - 1))
            state_r <= prs_pkg::RAIL_ON;
          else
            cnt_r <= cnt_r + 1'b1;
        end
        prs_pkg::RAIL_ON:
          state_r <= prs_pkg::RAIL_ON;
        default:
          state_r <= prs_pkg::RAIL_OFF;
      endcase
    end
  end

  always_comb
  begin
    enable_o = (state_r == prs_pkg::RAIL_RAMP) ||
               (state_r == prs_pkg::RAIL_ON);
    good_o   = (state_r == prs_pkg::RAIL_ON);
  end

  AST_DELAY_BEFORE_ENABLE: assert property (@(posedge mclk_i)
    disable iff (reset_i)
    $rose(trigger_i) |-> !enable_o [*8])
    else $error("rail enabled before startup delay");
endmodule

// file: rtl/prs_sequencer.sv
/*
  Rail sequencer and mode control with an I2C register slave.
  Assumes power_request, aux_group, setpoint select and I2C pins
  are synchronous to mclk_i; SDA open drain resolved outside.
*/
// Notes on behaviour
// - Power request high means active mode, low means sleep mode.
// - Rail four and linear rails one to three follow active mode.
// - Setpoint pin high picks primary setpoint, low picks alternate.
// - Rail four drops to lower alternate setpoint when scaling active.
// - Rail good output follows step-down rail one status.
// - External supply enable is driven as part of the sequence.
// - Main reset output is never driven.
// - Auxiliary reset pin is a digital input.
// - Auxiliary group high enables step-down rails one to three in active mode.
// - Auxiliary group low disables step-down rails one to three.
// - Spare auxiliary pin and external good input have no function.
// - I2C slave at seven-bit address 0x53.
// - Identity register returns a fixed configuration code.
`timescale 1ns/1ps
module prs_sequencer
#(
  // Arbitrary identity value
  parameter logic [7:0] DEVICE_IDENTITY = 8'h5A
)
(
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       power_request_input_i,
  input  wire logic       aux_group_input_i,
  input  wire logic       setpoint_select_i,
  input  wire logic       spare_aux_pin_i,
  input  wire logic       external_good_input_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            main_reset_output_low_o,
  output logic            main_reset_output_low_oe_o,
  output logic            active_mode_o,
  output logic [3:0]      group_a_enable_o,
  output logic [2:0]      step_down_enable_o,
  output logic [7:0]      step_down_setpoint_o,
  output logic            rail_good_output_o,
  output logic            supply_ok_output_o,
  output logic            external_supply_enable_o
);
  logic [3:0] a_en;
  logic [3:0] a_good;
  logic [2:0] b_en;
  logic [2:0] b_good;
  logic       b_trig;
  logic [7:0] primary_r;
  logic [7:0] alternate_r;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      active_mode_o <= 1'b0;
    else
      active_mode_o <= power_request_input_i;
  end

  assign b_trig = power_request_input_i & aux_group_input_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_group_a
      // rail four and linear rails follow mode
      prs_rail_ctl u_rail
      (
        .mclk_i    (mclk_i),
        .reset_i   (reset_i),
        .trigger_i (power_request_input_i),
        .enable_o  (a_en[g]),
        .good_o    (a_good[g])
      );
    end
    for (g = 0; g < 3; g++)
    begin : g_group_b
      prs_rail_ctl u_rail
      (
        .mclk_i    (mclk_i),
        .reset_i   (reset_i),
        .trigger_i (b_trig),
        .enable_o  (b_en[g]),
        .good_o    (b_good[g])
      );
    end
  endgenerate

  // aux low gates off at once
  always_comb
  begin
    group_a_enable_o   = a_en;
    step_down_enable_o = b_en & {3{b_trig}};
  end

  // setpoint selection; rail four scaled when low
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      step_down_setpoint_o <= prs_pkg::PRIMARY_RESET;
    else if (setpoint_select_i)
      step_down_setpoint_o <= primary_r;
    else
      step_down_setpoint_o <= alternate_r;
  end

  // rail good from rail one; external enable in sequence
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rail_good_output_o       <= 1'b0;
      supply_ok_output_o       <= 1'b0;
      external_supply_enable_o <= 1'b0;
    end
    else
    begin
      rail_good_output_o       <= b_good[0];
      supply_ok_output_o       <= &a_good;
      external_supply_enable_o <= &a_good;
    end
  end

  assign main_reset_output_low_o    = 1'b1;
  assign main_reset_output_low_oe_o = 1'b0;

  logic unused_pins;
  assign unused_pins = spare_aux_pin_i ^ external_good_input_i;

  // I2C slave
  typedef enum logic [5:0]
  {
    I2C_IDLE = 6'h01,
    I2C_ADDR = 6'h02,
    I2C_ACK  = 6'h04,
    I2C_WR   = 6'h08,
    I2C_RD   = 6'h10,
    I2C_RACK = 6'h20
  } prs_i2c_t;

  prs_i2c_t   st_r;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic       rw_r;
  logic       ptr_set_r;
  logic [7:0] ptr_r;
  logic       drive_r;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      prs_pkg::REG_DEVICE_IDENTITY:      read_reg = DEVICE_IDENTITY;
      prs_pkg::REG_PRIMARY_SETPOINT_4:   read_reg = primary_r;
      prs_pkg::REG_ALTERNATE_SETPOINT_4: read_reg = alternate_r;
      prs_pkg::REG_RAIL_STATUS:          read_reg = {1'b0, b_good, a_good};
      default:                           read_reg = prs_pkg::UNMAPPED_READ;
    endcase
  endfunction

  always_comb
  begin
    start_c = scl_q & scl_i & sda_q & ~sda_i;
    stop_c  = scl_q & scl_i & ~sda_q & sda_i;
    rise_c  = ~scl_q & scl_i;
    fall_c  = scl_q & ~scl_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i || stop_c)
    begin
      st_r <= I2C_IDLE; sh_r <= '0; bit_r <= '0; rw_r <= 1'b0;
      ptr_set_r <= 1'b0; drive_r <= 1'b0;
      if (reset_i) ptr_r <= '0;
    end
    else if (start_c)
    begin
      st_r <= I2C_ADDR; bit_r <= '0; ptr_set_r <= 1'b0; drive_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        I2C_ADDR, I2C_WR:
        begin
          if (rise_c)
          begin
            sh_r  <= {sh_r[6:0], sda_i};
            bit_r <= bit_r + 1'b1;
          end
          else if (fall_c && bit_r == 4'h8)
          begin
            bit_r <= '0;
            if (st_r == I2C_ADDR && sh_r[7:1] != prs_pkg::SLAVE_ADDR)
              st_r <= I2C_IDLE;
            else
            begin
              if (st_r == I2C_ADDR)
                rw_r <= sh_r[0];
              else if (!ptr_set_r)
              begin
                ptr_r <= sh_r; ptr_set_r <= 1'b1;
              end
              else
              begin
                ptr_r <= ptr_r + 1'b1;
              end
              st_r <= I2C_ACK; drive_r <= 1'b1;
            end
          end
        end
        I2C_ACK:
          if (fall_c)
          begin
            drive_r <= 1'b0;
            if (rw_r)
            begin
              sh_r <= read_reg(ptr_r); st_r <= I2C_RD;
              drive_r <= ~read_reg(ptr_r)[7];
            end
            else
              st_r <= I2C_WR;
          end
        I2C_RD:
          if (fall_c)
          begin
            bit_r <= bit_r + 1'b1;
            if (bit_r == 4'h7)
            begin
              drive_r <= 1'b0; st_r <= I2C_RACK; ptr_r <= ptr_r + 1'b1;
            end
            else
            begin
              sh_r <= {sh_r[6:0], 1'b0}; drive_r <= ~sh_r[6];
            end
          end
        I2C_RACK:
          if (rise_c)
          begin
            bit_r <= '0;
            st_r  <= sda_i ? I2C_IDLE : I2C_ACK;
          end
        default: st_r <= I2C_IDLE;
      endcase
    end
  end

  // Register writes to the setpoints
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      primary_r   <= prs_pkg::PRIMARY_RESET;
      alternate_r <= prs_pkg::ALTERNATE_RESET;
    end
    else if (st_r == I2C_WR && fall_c && bit_r == 4'h8 && ptr_set_r)
    begin
      // Data lands at the current pointer, which then steps on
      if (ptr_r == prs_pkg::REG_PRIMARY_SETPOINT_4)
        primary_r <= sh_r;
      if (ptr_r == prs_pkg::REG_ALTERNATE_SETPOINT_4)
        alternate_r <= sh_r;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_r;

  AST_MODE_FOLLOWS: assert property (@(posedge mclk_i) disable iff (reset_i)
    power_request_input_i |=> active_mode_o)
    else $error("active mode not entered");
  AST_GROUP_A_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
    !power_request_input_i |=> group_a_enable_o == 4'h0)
    else $error("group a on in sleep");
  AST_SETPOINT_SEL: assert property (@(posedge mclk_i) disable iff (reset_i)
    setpoint_select_i |=> step_down_setpoint_o == $past(primary_r))
    else $error("primary setpoint not selected");
  AST_SCALED: assert property (@(posedge mclk_i) disable iff (reset_i)
    !setpoint_select_i |=> step_down_setpoint_o == $past(alternate_r))
    else $error("alternate setpoint not selected");
  AST_RAIL_GOOD: assert property (@(posedge mclk_i) disable iff (reset_i)
    !b_trig ##1 !b_trig |=> !rail_good_output_o)
    else $error("rail good without rail one");
  AST_NO_RESET_DRIVE: assert property (@(posedge mclk_i)
    disable iff (reset_i) !main_reset_output_low_oe_o)
    else $error("main reset driven");
  AST_AUX_LOW_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
    !aux_group_input_i |-> step_down_enable_o == 3'h0)
    else $error("group b on with aux low");
  AST_ID_READ: assert property (@(posedge mclk_i) disable iff (reset_i)
    (st_r == I2C_ACK && fall_c && rw_r &&
     ptr_r == prs_pkg::REG_DEVICE_IDENTITY)
    |=> sh_r == DEVICE_IDENTITY)
    else $error("identity not loaded");
endmodule

// file: tb/prs_host.sv
/*
  Host model: power request, aux group, setpoint pin and I2C master.
  Assumes SDA has a pull-up and the slave pulls it low by its enable.
*/
`timescale 1ns/1ps
module prs_host
(
  input  wire logic mclk_i,
  input  wire logic sda_oe_i,
  output logic      power_request_o,
  output logic      aux_group_o,
  output logic      setpoint_select_o,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int Q = 10;
  logic          pull_low;
  assign sda_o = !(pull_low || sda_oe_i);
  initial
  begin
    power_request_o = 1'b0;
    aux_group_o = 1'b0;
    setpoint_select_o = 1'b1;
    scl_o = 1'b1;
    pull_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // power request, aux and setpoint pins set in the same step
  task automatic set_pins(input logic p, input logic a, input logic s);
    power_request_o = p;
    aux_group_o = a;
    setpoint_select_o = s;
  endtask
  task automatic start();
    pull_low = 1'b0;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    pull_low = 1'b1;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    pull_low = 1'b1;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    pull_low = 1'b0;
    tick(Q);
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull_low = !b;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    r = sda_o;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    ack = !a;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a1, a2, a3, a4;
    start();
    byte_io({dev, 1'b0}, r, a1);
    byte_io(ptr, r, a2);
    start();
    byte_io({dev, 1'b1}, r, a3);
    byte_io(8'hFF, d, a4);
    stop();
    ok = a1 & a2 & a3;
  endtask
  // write address, pointer, one data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] v, output logic ok);
    logic [7:0] r;
    logic       a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, r, a1);
    byte_io(ptr, r, a2);
    byte_io(v, r, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask
endmodule

// file: tb/prs_sequencer_tb.sv
/*
  Self-checking bench for the rail sequencer.
  Assumes prs_host drives the host pins and acts as I2C master.
*/
`timescale 1ns/1ps
module prs_sequencer_tb;
  // Arbitrary identity value
  localparam logic [7:0] ID = 8'hC3;
  logic       mclk, reset, spare, ext_good, pwr, aux, sel, scl, sda;
  logic       sda_drv, sda_oe, rst_low, rst_oe, active, rail_good;
  logic       sup_ok, external_supply_enable, ok;
  logic [3:0] grp_a;
  logic [2:0] sd_en;
  logic [7:0] setpt, d;
  int         errors;
  int         n_compared;
  int         cycles;

  prs_host host (.mclk_i(mclk), .sda_oe_i(sda_oe), .power_request_o(pwr),
    .aux_group_o(aux), .setpoint_select_o(sel), .scl_o(scl), .sda_o(sda));

  prs_sequencer #(.DEVICE_IDENTITY(ID)) DUT (.mclk_i(mclk),
    .reset_i(reset), .power_request_input_i(pwr), .aux_group_input_i(aux),
    .setpoint_select_i(sel), .spare_aux_pin_i(spare),
    .external_good_input_i(ext_good), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .main_reset_output_low_o(rst_low),
    .main_reset_output_low_oe_o(rst_oe), .active_mode_o(active),
    .group_a_enable_o(grp_a), .step_down_enable_o(sd_en),
    .step_down_setpoint_o(setpt), .rail_good_output_o(rail_good),
    .supply_ok_output_o(sup_ok), .external_supply_enable_o(external_supply_enable));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Ceiling well above the roughly 11500 cycles the tests need
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    reset = 1'b1;
    spare = 1'b0;
    ext_good = 1'b0;
    host.tick(3);
    reset = 1'b0;
    host.tick(1);
    chk({7'h0, rst_low}, 8'h01);
    chk({7'h0, rst_oe}, 8'h00);
    chk({7'h0, sda_drv}, 8'h00);
    chk({4'h0, grp_a}, 8'h00);
    $display("test reset done");
    host.set_pins(1'b1, 1'b0, 1'b1);
    host.tick(2);
    chk({7'h0, active}, 8'h01);
    host.tick(813);
    chk({4'h0, grp_a}, 8'h00);
    host.tick(15);
    chk({4'h0, grp_a}, 8'h0F);
    chk({5'h0, sd_en}, 8'h00);
    host.tick(20);
    chk({7'h0, sup_ok}, 8'h01);
    chk({7'h0, external_supply_enable}, 8'h01);
    chk({7'h0, rail_good}, 8'h00);
    $display("test active mode done");
    host.set_pins(1'b1, 1'b1, 1'b1);
    host.tick(815);
    chk({5'h0, sd_en}, 8'h00);
    host.tick(15);
    chk({5'h0, sd_en}, 8'h07);
    host.tick(20);
    chk({7'h0, rail_good}, 8'h01);
    host.set_pins(1'b1, 1'b0, 1'b1);
    host.tick(2);
    chk({5'h0, sd_en}, 8'h00);
    chk({4'h0, grp_a}, 8'h0F);
    $display("test aux group done");
    spare = 1'b1;
    ext_good = 1'b1;
    host.set_pins(1'b1, 1'b0, 1'b0);
    host.tick(3);
    chk(setpt, prs_pkg::ALTERNATE_RESET);
    chk({7'h0, external_supply_enable}, 8'h01);
    host.set_pins(1'b1, 1'b0, 1'b1);
    host.tick(3);
    chk(setpt, prs_pkg::PRIMARY_RESET);
    $display("test setpoint done");
    host.read_reg(prs_pkg::SLAVE_ADDR, prs_pkg::REG_DEVICE_IDENTITY, d, ok);
    chk(d, ID);
    chk({7'h0, ok}, 8'h01);
    host.read_reg(prs_pkg::SLAVE_ADDR, 8'h11, d, ok);
    chk(d, prs_pkg::ALTERNATE_RESET);
    host.read_reg(prs_pkg::SLAVE_ADDR, 8'h40, d, ok);
    chk(d, prs_pkg::UNMAPPED_READ);
    host.read_reg(7'h2A, 8'h7D, d, ok);
    chk({7'h0, ok}, 8'h00);
    host.write_reg(prs_pkg::SLAVE_ADDR, 8'h10, 8'h5C, ok);
    chk({7'h0, ok}, 8'h01);
    host.tick(3);
    chk(setpt, 8'h5C);
    host.read_reg(prs_pkg::SLAVE_ADDR, 8'h10, d, ok);
    chk(d, 8'h5C);
    $display("test register read done");
    host.set_pins(1'b0, 1'b0, 1'b1);
    host.tick(2);
    chk({4'h0, grp_a}, 8'h00);
    chk({7'h0, active}, 8'h00);
    host.set_pins(1'b0, 1'b1, 1'b1);
    host.tick(850);
    chk({5'h0, sd_en}, 8'h00);
    host.set_pins(1'b0, 1'b0, 1'b1);
    $display("test sleep mode done");
    final_report();
  end
endmodule
